/* occ_cfg.svh */
// register offsets, field positions and reset values of the compare block
// assumes a 32-bit word-aligned bus map with byte addresses below
`ifndef OCC_CFG_SVH
`define OCC_CFG_SVH

// per-channel register offsets, channel stride added on top
`define OCC_CH_STRIDE 8'h10
`define OCC_OFS_CTRL 8'h00
`define OCC_OFS_PRI 8'h04
`define OCC_OFS_SEC 8'h08
// interrupt registers
`define OCC_OFS_STAT 8'h20
`define OCC_OFS_EN 8'h24
`define OCC_OFS_CLR 8'h28

// control register field positions
`define OCC_BIT_SIDL 13
`define OCC_BIT_FLT 4
`define OCC_BIT_TSEL 3
`define OCC_MODE_HI 2
`define OCC_MODE_LO 0

// reset values
`define OCC_RST_CTRL 5'h00
`define OCC_RST_VAL 16'h0000
`define OCC_RST_EN 4'h0

// channel count and interrupt event count
`define OCC_NCH 2
`define OCC_NEV 4
`endif

/* occ_irq.sv */
// sticky interrupt status with enable and write-one-to-clear
// assumes event and clear inputs are one-cycle pulses on the same clock
`timescale 1ns/10ps
`default_nettype none
module occ_irq #(
    parameter int N = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // events, clears and enables
    input wire logic [N-1:0] ev,
    input wire logic [N-1:0] clr,
    input wire logic [N-1:0] en,
    // status and level interrupt
    output logic [N-1:0] status,
    output logic irq
);
    typedef struct packed {
        logic [N-1:0] stat;
    } occ_irq_st_t;

    occ_irq_st_t s_r;
    occ_irq_st_t s_nxt;

    // set wins over a clear in the same cycle
    always_comb
    begin
        s_nxt.stat = (s_r.stat & ~clr) | ev;
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign status = s_r.stat;
    assign irq = |(s_r.stat & en);
endmodule : occ_irq
`default_nettype wire

/* occ_load.sv */
// load model on one compare pin, with a fault line back to the block
// assumes the fault line is pulled up while nothing pulls it low
`timescale 1ns/10ps
`default_nettype none
module occ_load (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin seen and fault request
    input wire logic pin,
    input wire logic trip,
    // fault line and pulse count
    output logic fault_n,
    output logic [7:0] rises
);
    logic last_r;
    // pull-up: only low while a fault is requested
    assign fault_n = !trip;
    // count rising edges so pulse counts can be judged
    always_ff @(posedge clk)
    begin
        last_r <= pin;
        rises <= rst ? 8'h00 : rises + 8'(pin && !last_r);
    end
endmodule : occ_load
`default_nettype wire

/* occ_match.sv */
// equality detector between a selected time base count and a compare value
// assumes both time base counts are synchronous to the clock
`timescale 1ns/10ps
`default_nettype none
module occ_match #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // time bases and selection
    input wire logic [W-1:0] cnt_first,
    input wire logic [W-1:0] cnt_second,
    input wire logic sel_second,
    input wire logic [W-1:0] value,
    // one-cycle event on the first cycle of equality
    output logic ev
);
    typedef struct packed {
        logic eq;
    } occ_match_st_t;

    occ_match_st_t s_r;
    occ_match_st_t s_nxt;
    logic eq;

    // a prescaled timer holds a count for many cycles, so only the start counts
    always_comb
    begin
        eq = (sel_second ? cnt_second : cnt_first) == value;
        s_nxt.eq = eq;
        ev = eq & ~s_r.eq;
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
endmodule : occ_match
`default_nettype wire

/* occ_pkg.sv */
// types shared by the compare block files
// assumes occ_cfg.svh is included for widths
`default_nettype none
`include "occ_cfg.svh"
package occ_pkg;
    // compare_mode_select encodings
    typedef enum logic [2:0] {
        OCC_DIS = 3'b000,
        OCC_SETHI = 3'b001,
        OCC_SETLO = 3'b010,
        OCC_TOG = 3'b011,
        OCC_SINGLE = 3'b100,
        OCC_CONT = 3'b101,
        OCC_PWM = 3'b110,
        OCC_PWMF = 3'b111
    } occ_mode_t;

    // writable fields of compare_channel_control
    typedef struct packed {
        logic sidl;
        logic tsel;
        occ_mode_t mode;
    } occ_ctrl_t;

    // per-channel output state
    typedef struct packed {
        logic pin;
        logic flt;
        logic done;
        occ_mode_t last;
    } occ_chan_t;

    // whole state of the top module
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic rd_wait;
        logic [31:0] rdata;
        occ_ctrl_t [`OCC_NCH-1:0] ctrl;
        logic [`OCC_NCH-1:0][15:0] pri;
        logic [`OCC_NCH-1:0][15:0] sec;
        occ_chan_t [`OCC_NCH-1:0] ch;
        logic [`OCC_NEV-1:0] irq_en;
    } occ_state_t;
endpackage : occ_pkg
`default_nettype wire

/* occ_top.sv */
// two output compare channels with an ahb-lite register slave
// assumes time base counts, idle and fault inputs are synchronous to CLK_SYS
// assumes single word transfers and HREADY looped back from HREADYOUT
// assumes each fault input is pulled high while no fault is present
//
// Overview of operation
// R1: two identical channels, each with its own 16-bit control register.
// R2: idle stop bit set halts the channel while the cpu idles.
// R3: hardware sets the fault flag on a pwm fault; only hardware clears it.
// R4: fault flag is read-only, hardware cleared, resets to zero.
// R5: fault flag only updates in mode 111.
// R6: timebase select 1 picks second timer, 0 picks first timer.
// R7: mode 111 is pwm with the fault input enabled.
// R8: mode 110 is pwm with the fault input ignored.
// R9: mode 101 starts pin low, then continuous pulses.
// R10: mode 100 starts pin low, then exactly one pulse.
// R11: mode 011 toggles the pin on each compare event.
// R12: mode 010 starts pin high; compare event drives it low.
// R13: mode 001 starts pin low; compare event drives it high.
// R14: mode 000 disables the channel; this is the reset value.
// R15: unimplemented control bits read as zero.
// R16: primary match is the compare event; secondary match ends a pulse.
`timescale 1ns/10ps
`default_nettype none
`include "occ_cfg.svh"
module occ_top #(
    parameter int TW = 16
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // time bases and system state
    input wire logic [TW-1:0] FIRST_GENERAL_TIMER,
    input wire logic [TW-1:0] SECOND_GENERAL_TIMER,
    input wire logic CPU_IDLE,
    input wire logic [`OCC_NCH-1:0] FAULT_N,
    // compare outputs and interrupt
    output logic [`OCC_NCH-1:0] COMPARE_OUTPUT_PIN,
    output logic IRQ
);
    // whole block state, registered once
    occ_pkg::occ_state_t s_r;
    occ_pkg::occ_state_t s_nxt;

    // one-cycle match events per channel
    logic [`OCC_NCH-1:0] ev_pri;
    logic [`OCC_NCH-1:0] ev_sec;
    logic [`OCC_NCH-1:0] ev_zero;

    // interrupt events, clears and sticky status
    logic [`OCC_NEV-1:0] irq_ev;
    logic [`OCC_NEV-1:0] irq_clr;
    logic [`OCC_NEV-1:0] irq_stat;

    // address phase accepted this cycle
    logic take;

    // register index within a channel block, and channel number
    // channel blocks repeat every stride, so decoding is a mask
    function automatic logic [7:0] occ_reg_ofs(input logic [7:0] a);
        occ_reg_ofs = a & (`OCC_CH_STRIDE - 8'h01);
    endfunction : occ_reg_ofs

    function automatic logic occ_is_chan(input logic [7:0] a, input int i);
        occ_is_chan = (a & ~(`OCC_CH_STRIDE - 8'h01)) == 8'(i * `OCC_CH_STRIDE);
    endfunction : occ_is_chan

    // control register read image; bits 15:14 and 12:5 stay zero
    function automatic logic [15:0] occ_ctrl_word(input occ_pkg::occ_ctrl_t c,
                                                   input logic flt);
        logic [15:0] w;
        w = 16'h0000; // see R15
        w[`OCC_BIT_SIDL] = c.sidl;
        w[`OCC_BIT_FLT] = flt;
        w[`OCC_BIT_TSEL] = c.tsel;
        w[`OCC_MODE_HI:`OCC_MODE_LO] = c.mode;
        occ_ctrl_word = w;
    endfunction : occ_ctrl_word

    // matches: primary value, secondary value and period start at zero
    // all three watch the same selected time base
    for (genvar i = 0; i < `OCC_NCH; i++)
    begin : g_ch
        occ_match #(.W(TW)) u_pri (
            .clk(CLK_SYS),
            .rst(RST),
            .cnt_first(FIRST_GENERAL_TIMER),
            .cnt_second(SECOND_GENERAL_TIMER),
            .sel_second(s_r.ctrl[i].tsel), // see R6
            .value(s_r.pri[i]),
            .ev(ev_pri[i])
        );
        occ_match #(.W(TW)) u_sec (
            .clk(CLK_SYS),
            .rst(RST),
            .cnt_first(FIRST_GENERAL_TIMER),
            .cnt_second(SECOND_GENERAL_TIMER),
            .sel_second(s_r.ctrl[i].tsel),
            .value(s_r.sec[i]),
            .ev(ev_sec[i])
        );
        occ_match #(.W(TW)) u_zero (
            .clk(CLK_SYS),
            .rst(RST),
            .cnt_first(FIRST_GENERAL_TIMER),
            .cnt_second(SECOND_GENERAL_TIMER),
            .sel_second(s_r.ctrl[i].tsel),
            .value('0),
            .ev(ev_zero[i])
        );
    end

    // sticky status: bits 1:0 compare events, bits 3:2 fault events
    // compare events count unless the channel is halted, disabled or changing mode
    occ_irq #(.N(`OCC_NEV)) u_irq (
        .clk(CLK_SYS),
        .rst(RST),
        .ev(irq_ev),
        .clr(irq_clr),
        .en(s_r.irq_en),
        .status(irq_stat),
        .irq(IRQ)
    );

    // address phase accepted only when the bus is ready
    // a select without a transfer type is ignored
    assign take = HSEL & HREADY & HTRANS[1];

    // bus slave, register file and channel behaviour
    always_comb
    begin
        occ_pkg::occ_chan_t ch;
        occ_pkg::occ_ctrl_t c;
        logic halt;
        logic [7:0] ofs;
        s_nxt = s_r;
        irq_ev = '0;
        irq_clr = '0;
        ch = '0;
        c = '0;
        halt = 1'b0;

        // offset within a channel block; upper bits pick the channel
        ofs = occ_reg_ofs(s_r.addr);

        // data phase of a write: word transfers only
        // the address was captured one edge earlier
        s_nxt.wr = 1'b0;
        if (s_r.wr)
        begin
            for (int i = 0; i < `OCC_NCH; i++)
            begin
                if (occ_is_chan(s_r.addr, i))
                begin
                    unique case (ofs)
                        `OCC_OFS_CTRL:
                        begin
                            // fault bit is not writable here
                            s_nxt.ctrl[i].sidl = HWDATA[`OCC_BIT_SIDL]; // see R4
                            s_nxt.ctrl[i].tsel = HWDATA[`OCC_BIT_TSEL];
                            s_nxt.ctrl[i].mode =
                                occ_pkg::occ_mode_t'(HWDATA[`OCC_MODE_HI:`OCC_MODE_LO]);
                        end
                        `OCC_OFS_PRI: s_nxt.pri[i] = HWDATA[15:0];
                        `OCC_OFS_SEC: s_nxt.sec[i] = HWDATA[15:0];
                        default: ;
                    endcase
                end
            end

            // interrupt enable is plain storage
            if (s_r.addr == `OCC_OFS_EN)
                s_nxt.irq_en = HWDATA[`OCC_NEV-1:0];
            // clear is a pulse; a same-cycle event still sets the bit
            if (s_r.addr == `OCC_OFS_CLR)
                irq_clr = HWDATA[`OCC_NEV-1:0];
        end

        // reads take one wait cycle so the data comes from a flip-flop
        // hrdata then stands until the next read completes
        s_nxt.rd = 1'b0;
        s_nxt.rd_wait = 1'b0;
        if (s_r.rd)
        begin
            s_nxt.rd_wait = 1'b1;
            s_nxt.rdata = 32'h0000_0000; // unmapped reads return zero
            for (int i = 0; i < `OCC_NCH; i++)
            begin
                if (occ_is_chan(s_r.addr, i))
                begin
                    unique case (ofs)
                        `OCC_OFS_CTRL:
                            s_nxt.rdata[15:0] = occ_ctrl_word(s_r.ctrl[i], s_r.ch[i].flt);
                        `OCC_OFS_PRI: s_nxt.rdata[15:0] = s_r.pri[i];
                        `OCC_OFS_SEC: s_nxt.rdata[15:0] = s_r.sec[i];
                        default: ;
                    endcase
                end
            end

            // status and enable share one layout, upper bits zero
            if (s_r.addr == `OCC_OFS_STAT)
                s_nxt.rdata[`OCC_NEV-1:0] = irq_stat;
            if (s_r.addr == `OCC_OFS_EN)
                s_nxt.rdata[`OCC_NEV-1:0] = s_r.irq_en;
        end

        // new address phase; a read wait blocks it via hreadyout
        // hsize is not checked: only whole words are expected
        if (take)
        begin
            s_nxt.addr = HADDR[7:0];
            s_nxt.wr = HWRITE;
            s_nxt.rd = ~HWRITE;
        end

        // each channel runs the same logic off its own registers
        for (int i = 0; i < `OCC_NCH; i++) // see R1
        begin
            c = s_r.ctrl[i];
            ch = s_r.ch[i];

            // halted channels freeze the pin except on a mode change, and drop their events
            halt = c.sidl & CPU_IDLE; // see R2

            if (c.mode != ch.last)
            begin
                // mode change: load the initial pin level
                // the first cycle of a new mode ignores any match
                ch.last = c.mode;
                ch.done = 1'b0;
                unique case (c.mode)
                    occ_pkg::OCC_SETLO: ch.pin = 1'b1; // see R12
                    occ_pkg::OCC_TOG: ch.pin = ch.pin;
                    default: ch.pin = 1'b0; // see R9 see R10 see R13 see R14
                endcase
            end
            else if (!halt)
            begin
                unique case (c.mode)
                    occ_pkg::OCC_DIS: ch.pin = 1'b0; // see R14
                    occ_pkg::OCC_SETHI:
                        if (ev_pri[i])
                            ch.pin = 1'b1; // see R13
                    occ_pkg::OCC_SETLO:
                        if (ev_pri[i])
                            ch.pin = 1'b0; // see R12
                    occ_pkg::OCC_TOG:
                        if (ev_pri[i])
                            ch.pin = ~ch.pin; // see R11
                    occ_pkg::OCC_SINGLE:
                    begin
                        // after the one pulse the channel stays quiet
                        // rewriting another mode arms it again
                        if (!ch.done && ev_pri[i])
                            ch.pin = 1'b1; // see R10 see R16
                        if (!ch.done && ev_sec[i] && ch.pin)
                        begin
                            ch.pin = 1'b0;
                            ch.done = 1'b1;
                        end
                    end
                    occ_pkg::OCC_CONT:
                    begin
                        // each primary match starts a pulse, each secondary ends it
                        // equal primary and secondary values leave the pin low
                        if (ev_pri[i])
                            ch.pin = 1'b1; // see R9 see R16
                        if (ev_sec[i])
                            ch.pin = 1'b0;
                    end
                    occ_pkg::OCC_PWM, occ_pkg::OCC_PWMF:
                    begin
                        // period starts at zero, duty ends at the primary value
                        if (ev_zero[i])
                            ch.pin = s_r.pri[i] != '0; // see R8
                        if (ev_pri[i])
                            ch.pin = 1'b0; // see R7
                        // fault input only acts in the faulted pwm mode
                        // a cleared fault resumes at the next period start
                        if (c.mode == occ_pkg::OCC_PWMF)
                        begin
                            if (!FAULT_N[i])
                            begin
                                // fault present: pin parked low, flag held set
                                ch.flt = 1'b1; // see R3 see R5
                                ch.pin = 1'b0;
                            end
                            else if (ch.flt && ev_zero[i])
                                ch.flt = 1'b0; // see R3
                            else if (ch.flt)
                                ch.pin = 1'b0;
                        end
                    end
                endcase
            end

            // interrupt events: accepted compare, fault rising
            // a mode change cycle raises no compare event
            irq_ev[i] = ev_pri[i] & ~halt & (c.mode != occ_pkg::OCC_DIS)
                        & (c.mode == s_r.ch[i].last);
            irq_ev[i + `OCC_NCH] = ch.flt & ~s_r.ch[i].flt;
            s_nxt.ch[i] = ch;
        end
    end

    // one register for all state; every field clears on reset
    // reset is synchronous, so compare pins and irq go low at the first clock edge of the pulse
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            s_r <= '0; // see R4 see R14
            s_r.irq_en <= `OCC_RST_EN;
        end
        else
            s_r <= s_nxt;
    end

    // bus answers: one wait state on reads only, never an error
    assign HREADYOUT = ~s_r.rd;
    assign HRESP = 1'b0;
    assign HRDATA = s_r.rdata;

    // compare pins straight from flip-flops, free of glitches
    always_comb
    begin
        for (int i = 0; i < `OCC_NCH; i++)
            COMPARE_OUTPUT_PIN[i] = s_r.ch[i].pin;
    end
endmodule : occ_top
`default_nettype wire

/* occ_top_chk.sv */
// assertions on the compare block ports
// assumes binding to occ_top, one clock and one reset
`timescale 1ns/10ps
`default_nettype none
module occ_chk #(
    parameter int TW = 16
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // bus
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // time bases, idle, fault and outputs
    input wire logic [TW-1:0] FIRST_GENERAL_TIMER,
    input wire logic [TW-1:0] SECOND_GENERAL_TIMER,
    input wire logic CPU_IDLE,
    input wire logic [1:0] FAULT_N,
    input wire logic [1:0] COMPARE_OUTPUT_PIN,
    input wire logic IRQ
);
    logic take;
    logic [3:0] act_r;
    logic [3:0] wr_r;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    // transfer accepted this cycle
    assign take = HSEL && HREADY && HTRANS[1];
    // short history of causes; pins may only move a few cycles after one
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            act_r <= 4'h0;
            wr_r <= 4'h0;
        end
        else
        begin
            act_r <= {act_r[2:0], take || $changed(FIRST_GENERAL_TIMER)
                || $changed(SECOND_GENERAL_TIMER) || $changed(FAULT_N) || $changed(CPU_IDLE)};
            wr_r <= {wr_r[2:0], take && HWRITE};
        end
    end
    AST_RESP_OKAY: assert property (!HRESP)
        else $error("error response seen");
    AST_READ_WAIT: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
    AST_WRITE_NOWAIT: assert property (take && HWRITE |=> HREADYOUT)
        else $error("write stalled");
    AST_WAIT_CAUSE: assert property ($fell(HREADYOUT) |-> $past(take && !HWRITE))
        else $error("wait state without read");
    AST_RESET_IDLE: assert property ($fell(RST) |-> !IRQ && COMPARE_OUTPUT_PIN == 2'b00)
        else $error("outputs not idle after reset");
    AST_PIN_CAUSE: assert property ($changed(COMPARE_OUTPUT_PIN) |-> act_r != 4'h0 || $past(RST))
        else $error("pin moved without cause");
    AST_IRQ_RISE: assert property ($rose(IRQ) |-> act_r != 4'h0)
        else $error("irq rose without cause");
    AST_IRQ_FALL: assert property ($fell(IRQ) |-> wr_r != 4'h0 || $past(RST))
        else $error("irq fell without write");
endmodule : occ_chk
bind occ_top occ_chk #(.TW(TW)) chk_u (.CLK_SYS, .RST, .HSEL, .HTRANS, .HWRITE, .HREADY,
    .HREADYOUT, .HRESP, .FIRST_GENERAL_TIMER, .SECOND_GENERAL_TIMER, .CPU_IDLE, .FAULT_N,
    .COMPARE_OUTPUT_PIN, .IRQ);
`default_nettype wire

/* tb.sv */
// self-checking bench for the compare block
// assumes occ_top, occ_load and the bound checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk;
    logic rst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [15:0] t1;
    logic [15:0] t2;
    logic idle;
    logic [1:0] trip;
    logic [1:0] flt_n;
    logic [1:0] pin;
    logic irq;
    logic [7:0] rises0;
    logic [7:0] rises1;
    logic [31:0] q;
    int failures;
    int n_checks;
    // block under test, bus ready looped back
    occ_top #(.TW(16)) dut_u (.CLK_SYS(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .FIRST_GENERAL_TIMER(t1),
        .SECOND_GENERAL_TIMER(t2), .CPU_IDLE(idle), .FAULT_N(flt_n),
        .COMPARE_OUTPUT_PIN(pin), .IRQ(irq));
    // loads on both pins
    occ_load ld0_u (.clk(clk), .rst(rst), .pin(pin[0]), .trip(trip[0]),
        .fault_n(flt_n[0]), .rises(rises0));
    occ_load ld1_u (.clk(clk), .rst(rst), .pin(pin[1]), .trip(trip[1]),
        .fault_n(flt_n[1]), .rises(rises1));
    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic final_report;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("mismatch %s exp %h got %h", nm, e, g);
            failures++;
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    // one single transfer; waits on ready, never on a fixed count
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 40);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 40);
        q = hrdata;
        chk("bus_wait", 32'h0, 32'(n >= 40));
        chk("bus_resp", 32'h0, 32'(hresp));
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask : rd
    task automatic cnt(input logic [15:0] a, input logic [15:0] b);
        t1 <= a;
        t2 <= b;
        cyc(3);
    endtask : cnt
    task automatic cz;
        cnt(16'h1, 16'h0);
        cnt(16'h0, 16'h0);
    endtask : cz
    // match on the unselected base first, which must do nothing
    task automatic hit(input int c, input logic [15:0] p);
        logic o;
        o = pin[c];
        if (c == 0) cnt(16'h0, p); else cnt(p, 16'h0);
        chk("other_base", 32'(o), 32'(pin[c]));
        cnt(p, p);
        cnt(16'h0, 16'h0);
    endtask : hit
    task automatic t_regs;
        for (int i = 0; i < 10; i++)
        begin
            rd(8'(i * 4));
            chk("reset_val", 32'h0, q);
        end
        chk("reset_pins", 32'h0, 32'({irq, pin}));
        for (int c = 0; c < 2; c++)
        begin
            wr(8'(c * 16), 32'hFFFF_FFFF);
            rd(8'(c * 16));
            chk("ctrl_bits", 32'h0000_200F, q);
            wr(8'(c * 16), 32'h0);
        end
        wr(8'h0C, 32'h1234);
        rd(8'h0C);
        chk("unmapped", 32'h0, q);
        $display("regs done");
    endtask : t_regs
    task automatic t_modes;
        for (int c = 0; c < 2; c++)
        begin
            wr(8'(c * 16 + 4), 32'h5);
            for (int m = 1; m < 4; m++)
            begin
                wr(8'(c * 16), 32'(m + c * 8));
                cyc(3);
                chk("init", 32'(m == 2), 32'(pin[c]));
                hit(c, 16'h5);
                chk("ev1", 32'(m != 2), 32'(pin[c]));
                hit(c, 16'h5);
                chk("ev2", 32'(m == 1), 32'(pin[c]));
            end
        end
        $display("modes done");
    endtask : t_modes
    task automatic t_pulse;
        logic [7:0] r;
        wr(8'h04, 32'h5);
        wr(8'h08, 32'h9);
        for (int m = 4; m < 6; m++)
        begin
            r = rises0;
            wr(8'h00, 32'(m));
            cyc(3);
            chk("p_init", 32'h0, 32'(pin[0]));
            cnt(16'h5, 16'h0);
            chk("p_on", 32'h1, 32'(pin[0]));
            cnt(16'h9, 16'h0);
            chk("p_off", 32'h0, 32'(pin[0]));
            cnt(16'h5, 16'h0);
            cnt(16'h9, 16'h0);
            chk("p_count", 32'(m - 3), 32'(rises0 - r));
        end
        $display("pulse done");
    endtask : t_pulse
    task automatic t_pwm;
        wr(8'h00, 32'h6);
        cz;
        chk("pwm_hi", 32'h1, 32'(pin[0]));
        cnt(16'h5, 16'h0);
        chk("pwm_lo", 32'h0, 32'(pin[0]));
        trip[0] <= 1'b1;
        cz;
        chk("pwm_nf", 32'h1, 32'(pin[0]));
        rd(8'h00);
        chk("flt_off", 32'h6, q);
        trip[0] <= 1'b0;
        wr(8'h00, 32'h7);
        cz;
        chk("pwmf_hi", 32'h1, 32'(pin[0]));
        trip[0] <= 1'b1;
        cyc(4);
        chk("flt_pin", 32'h0, 32'(pin[0]));
        wr(8'h00, 32'h7);
        rd(8'h00);
        chk("flt_set", 32'h17, q);
        trip[0] <= 1'b0;
        cyc(3);
        rd(8'h00);
        chk("flt_hold", 32'h17, q);
        cz;
        rd(8'h00);
        chk("flt_clr", 32'h7, q);
        chk("pwm_back", 32'h1, 32'(pin[0]));
        $display("pwm done");
    endtask : t_pwm
    task automatic t_idle;
        logic p;
        logic [7:0] r1;
        wr(8'h14, 32'h7);
        wr(8'h10, 32'h200B);
        cyc(3);
        p = pin[1];
        r1 = rises1;
        idle <= 1'b1;
        hit(1, 16'h7);
        chk("idle_stop", 32'(p), 32'(pin[1]));
        wr(8'h10, 32'h000B);
        hit(1, 16'h7);
        chk("idle_run", 32'(!p), 32'(pin[1]));
        chk("idle_rises", 32'(!p), 32'(rises1 - r1));
        idle <= 1'b0;
        $display("idle done");
    endtask : t_idle
    task automatic t_irq;
        wr(8'h00, 32'h1);
        wr(8'h28, 32'hF);
        wr(8'h24, 32'h1);
        rd(8'h20);
        chk("st_clr", 32'h0, q);
        chk("irq_off", 32'h0, 32'(irq));
        cnt(16'h5, 16'h0);
        rd(8'h20);
        chk("st_ev", 32'h1, q);
        chk("irq_on", 32'h1, 32'(irq));
        wr(8'h24, 32'h0);
        cyc(1);
        chk("irq_mask", 32'h0, 32'(irq));
        wr(8'h20, 32'hE);
        wr(8'h24, 32'h1);
        cyc(1);
        chk("irq_unmask", 32'h1, 32'(irq));
        wr(8'h28, 32'h1);
        cyc(1);
        chk("irq_clr", 32'h0, 32'(irq));
        rd(8'h20);
        chk("st_after", 32'h0, q);
        $display("irq done");
    endtask : t_irq
    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #300000;
        failures++;
        final_report;
    end
    // main sequence
    initial
    begin
        {rst, hsel, haddr, htrans, hwrite, hwdata} = {1'b1, 68'h0};
        {t1, t2, idle, trip} = 35'h0;
        failures = 0;
        n_checks = 0;
        cyc(16);
        rst <= 1'b0;
        cyc(1);
        t_regs;
        t_modes;
        t_pulse;
        t_pwm;
        t_idle;
        t_irq;
        final_report;
    end
endmodule : tb
`default_nettype wire
